// file: uaxr_top.sv
// asynchronous receive extensions: sampling, auto-baud, one-wire, line driver, infrared
`timescale 1ns/1ps
`default_nettype none
module uaxr_top #(
    parameter logic [15:0] BAUD_INIT = uaxr_pkg::BAUD_RESET
) (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic [1:0]  receive_mode_select_i,
    input  wire logic [1:0]  communication_mode_select_i,
    input  wire logic        wait_break_any_length_i,
    input  wire logic        loopback_enable_i,
    input  wire logic        open_drain_enable_i,
    input  wire logic        line_driver_mode_enable_i,
    input  wire logic        ir_event_select_i,
    input  wire logic        ir_event_i,
    input  wire logic [1:0]  ir_pulse_scheme_i,
    input  wire logic [7:0]  ir_pulse_cycles_i,
    input  wire logic [7:0]  ir_min_width_i,
    input  wire logic        baud_load_i,
    input  wire logic [15:0] baud_i,
    input  wire logic        sync_mismatch_clear_i,
    input  wire logic        rxd_i,
    input  wire logic        txd_i,
    input  wire logic        tx_valid_i,
    input  wire logic [7:0]  tx_data_i,
    input  wire logic        rx_ready_i,
    output logic             txd_o,
    output logic             txd_oe_o,
    output logic             driver_direction_out_o,
    output logic             tx_ready_o,
    output logic             rx_valid_o,
    output logic [7:0]       rx_data_o,
    output logic             rx_frame_error_o,
    output logic             rx_overrun_o,
    output logic [15:0]      baud_o,
    output logic             sync_field_mismatch_flag_o
);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uaxr_rx_t;
    typedef enum logic [2:0] {TX_IDLE, TX_GUARD, TX_START, TX_DATA, TX_STOP} uaxr_tx_t;
    typedef enum logic [2:0] {AB_BREAK, AB_GAP, AB_SYNC, AB_MEAS, AB_RUN} uaxr_ab_t;

    // mode decode
    logic infrared_mode;
    logic double_speed;
    logic generic_autobaud_mode;
    logic constrained_autobaud_mode;
    logic auto_mode;
    logic [4:0] s_max;
    logic [4:0] s_first;
    logic [4:0] s_mid;
    assign infrared_mode = communication_mode_select_i == uaxr_pkg::COMM_INFRARED_MODE;
    assign double_speed = receive_mode_select_i == uaxr_pkg::RX_DOUBLE_MODE && !infrared_mode;
    assign generic_autobaud_mode = receive_mode_select_i == uaxr_pkg::GENERIC_AUTOBAUD;
    assign constrained_autobaud_mode = receive_mode_select_i == uaxr_pkg::CONSTRAINED_AUTOBD;
    assign auto_mode = generic_autobaud_mode || constrained_autobaud_mode;
    // samples per bit and vote positions, normal otherwise
    assign s_max = double_speed ? uaxr_pkg::SAMPLES_DOUBLE : uaxr_pkg::SAMPLES_NORMAL;
    assign s_first = double_speed ? uaxr_pkg::VOTE_FIRST_DOUBLE : uaxr_pkg::VOTE_FIRST_NORMAL;
    assign s_mid = double_speed ? uaxr_pkg::VOTE_MID_DOUBLE : uaxr_pkg::VOTE_MID_NORMAL;

    // sample tick: 128 ticks per baud-setting clocks, same for both speeds
    logic [16:0] acc_q;
    logic [16:0] acc_sum;
    logic [16:0] acc_rem;
    logic        tick;
    assign acc_sum = acc_q + uaxr_pkg::TICK_STEP;
    assign tick = acc_sum >= {1'b0, baud_o};
    assign acc_rem = acc_sum - {1'b0, baud_o};
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            acc_q <= '0;
        end else if (tick) begin
            acc_q <= (acc_rem >= {1'b0, baud_o}) ? 17'h00000 : acc_rem;
        end else begin
            acc_q <= acc_sum;
        end
    end

    // receiver source selection and infrared decode
    logic line_raw;
    logic ir_pulse_in;
    logic [7:0] pw_q;
    logic [4:0] hold_q;
    logic zero_hold_q;
    logic rx_line;
    assign line_raw = loopback_enable_i ? txd_i : rxd_i;
    assign ir_pulse_in = ir_event_select_i ? ir_event_i : !line_raw;
    assign rx_line = infrared_mode ? !zero_hold_q : line_raw;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pw_q <= '0;
            hold_q <= '0;
            zero_hold_q <= 1'b0;
        end else begin
            pw_q <= ir_pulse_in ? ((pw_q == 8'hff) ? pw_q : pw_q + 8'h01) : 8'h00;
            if (ir_pulse_in && {1'b0, pw_q} + 9'h001 >= {1'b0, ir_min_width_i} && !zero_hold_q) begin
                zero_hold_q <= 1'b1;
                hold_q <= '0;
            end else if (zero_hold_q && tick) begin
                hold_q <= hold_q + 5'h01;
                if (hold_q == s_max - 5'h01) begin
                    zero_hold_q <= 1'b0;
                end
            end
        end
    end

    // receive state machine with three-sample majority vote
    uaxr_rx_t rx_state_q;
    logic [4:0] scnt_q;
    logic [1:0] zeros_q;
    logic [1:0] zeros_n;
    logic [2:0] rbit_q;
    logic [7:0] rsh_q;
    logic vote_at;
    logic decide;
    logic bitv;
    logic rx_en;
    logic rx_done;
    logic rx_ferr;
    uaxr_ab_t ab_q;
    assign rx_en = !auto_mode || ab_q == AB_RUN;
    assign vote_at = tick && (scnt_q == s_first || scnt_q == s_mid || scnt_q == s_mid + 5'h01);
    assign zeros_n = zeros_q + {1'b0, vote_at && !rx_line};
    assign decide = tick && scnt_q == s_mid + 5'h01;
    assign bitv = zeros_n < 2'h2;
    assign rx_done = rx_state_q == RX_STOP && decide;
    assign rx_ferr = !bitv;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_state_q <= RX_IDLE;
            scnt_q <= '0;
            zeros_q <= '0;
            rbit_q <= '0;
            rsh_q <= '0;
        end else if (rx_state_q == RX_IDLE) begin
            if (tick && rx_en && !rx_line) begin
                rx_state_q <= RX_START;
                scnt_q <= 5'h02; // this tick is sample 1
                zeros_q <= '0;
            end
        end else if (tick) begin
            zeros_q <= zeros_n;
            scnt_q <= scnt_q + 5'h01;
            unique case (rx_state_q)
                RX_START: begin
                    if (decide && bitv) begin
                        rx_state_q <= RX_IDLE; // false start rejected
                    end
                end
                RX_DATA: begin
                    if (decide) begin
                        rsh_q <= {bitv, rsh_q[7:1]};
                    end
                end
                RX_STOP: begin
                    if (decide) begin
                        rx_state_q <= RX_IDLE; // next start may follow the vote
                    end
                end
                RX_IDLE: begin
                end
            endcase
            if (scnt_q == s_max && rx_state_q != RX_STOP) begin
                scnt_q <= 5'h01;
                zeros_q <= '0;
                rbit_q <= (rx_state_q == RX_START) ? 3'h0 : rbit_q + 3'h1;
                if (rx_state_q == RX_START) begin
                    rx_state_q <= RX_DATA;
                end else if (rbit_q == uaxr_pkg::LAST_DATA_BIT) begin
                    rx_state_q <= RX_STOP;
                end
            end
        end
    end

    // hand-off word waits here while the buffer is full
    logic pend_v_q;
    logic [8:0] pend_d_q;
    logic buf_in_ready;
    logic push;
    assign push = pend_v_q && buf_in_ready;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pend_v_q <= 1'b0;
            pend_d_q <= '0;
            rx_overrun_o <= 1'b0;
        end else begin
            rx_overrun_o <= rx_done && pend_v_q && !push;
            if (rx_done && (!pend_v_q || push)) begin
                pend_v_q <= 1'b1;
                pend_d_q <= {rx_ferr, rsh_q};
            end else if (push) begin
                pend_v_q <= 1'b0;
            end
        end
    end

    // two-entry buffer: output register plus spare
    logic sp_v_q;
    logic [8:0] sp_d_q;
    logic pop;
    assign buf_in_ready = !sp_v_q;
    assign pop = rx_valid_o && rx_ready_i;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_valid_o <= 1'b0;
            rx_data_o <= '0;
            rx_frame_error_o <= 1'b0;
            sp_v_q <= 1'b0;
            sp_d_q <= '0;
        end else if (!rx_valid_o || pop) begin
            if (sp_v_q) begin
                rx_valid_o <= 1'b1;
                {rx_frame_error_o, rx_data_o} <= sp_d_q;
                sp_v_q <= 1'b0;
            end else begin
                rx_valid_o <= push;
                {rx_frame_error_o, rx_data_o} <= pend_d_q;
            end
        end else if (push) begin
            sp_v_q <= 1'b1;
            sp_d_q <= pend_d_q;
        end
    end

    // auto-baud: break, sync measurement over eight bit times
    logic prev_q;
    logic [3:0] lowc_q;
    logic [16:0] cnt_q;
    logic [16:0] seg_q;
    logic [16:0] t1_q;
    logic [2:0] falls_q;
    logic bad_q;
    logic edge_seen;
    logic fall_seen;
    logic meas_end;
    logic break_seen;
    logic in_range;
    logic gen_load;
    logic lin_load;
    logic lin_bad;
    assign edge_seen = rx_line != prev_q;
    assign fall_seen = edge_seen && !rx_line;
    assign meas_end = ab_q == AB_MEAS && fall_seen && falls_q == uaxr_pkg::SYNC_FALL_EDGES - 3'h1;
    assign break_seen = !rx_line && ((generic_autobaud_mode && wait_break_any_length_i)
                        || lowc_q >= uaxr_pkg::BREAK_MIN_CYCLES - 4'h1);
    assign in_range = cnt_q >= uaxr_pkg::BAUD_VALID_MIN && cnt_q <= uaxr_pkg::BAUD_VALID_MAX;
    assign gen_load = meas_end && generic_autobaud_mode && in_range;
    assign lin_bad = bad_q || (edge_seen && t1_q != '0
                     && (seg_q < {1'b0, t1_q[16:1]} || seg_q > t1_q + {1'b0, t1_q[16:1]}));
    assign lin_load = meas_end && constrained_autobaud_mode && !lin_bad && cnt_q <= uaxr_pkg::BAUD_VALID_MAX;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prev_q <= 1'b1;
            lowc_q <= '0;
        end else begin
            prev_q <= rx_line;
            lowc_q <= rx_line ? 4'h0 : ((lowc_q == 4'hf) ? lowc_q : lowc_q + 4'h1);
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i || !auto_mode) begin
            ab_q <= AB_BREAK;
            cnt_q <= '0;
            seg_q <= '0;
            t1_q <= '0;
            falls_q <= '0;
            bad_q <= 1'b0;
        end else begin
            unique case (ab_q)
                AB_BREAK: begin
                    if (break_seen) begin
                        ab_q <= AB_GAP;
                    end
                end
                AB_GAP: begin
                    if (rx_line) begin
                        ab_q <= AB_SYNC;
                    end
                end
                AB_SYNC: begin
                    if (!rx_line) begin
                        ab_q <= AB_MEAS;
                        cnt_q <= 17'h00001;
                        seg_q <= 17'h00001;
                        t1_q <= '0;
                        falls_q <= '0;
                        bad_q <= 1'b0;
                    end
                end
                AB_MEAS: begin
                    cnt_q <= (cnt_q == 17'h1ffff) ? cnt_q : cnt_q + 17'h00001;
                    seg_q <= (seg_q == 17'h1ffff) ? seg_q : seg_q + 17'h00001;
                    if (edge_seen) begin
                        seg_q <= 17'h00001;
                        bad_q <= lin_bad;
                        if (t1_q == '0) begin
                            t1_q <= seg_q;
                        end
                        if (fall_seen) begin
                            falls_q <= falls_q + 3'h1;
                        end
                    end
                    if (meas_end) begin
                        ab_q <= AB_RUN;
                    end
                end
                AB_RUN: begin
                    if (rx_done && rx_ferr && rsh_q == 8'h00) begin
                        ab_q <= AB_BREAK; // break character restarts detection
                    end
                end
                default: begin
                    ab_q <= AB_BREAK;
                end
            endcase
        end
    end

    // baud setting and sync mismatch flag; hardware set wins
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            baud_o <= BAUD_INIT;
        end else if (gen_load || lin_load) begin
            baud_o <= cnt_q[15:0];
        end else if (baud_load_i) begin
            baud_o <= baud_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync_field_mismatch_flag_o <= 1'b0;
        end else if (meas_end && constrained_autobaud_mode && lin_bad) begin
            sync_field_mismatch_flag_o <= 1'b1;
        end else if (sync_mismatch_clear_i) begin
            sync_field_mismatch_flag_o <= 1'b0;
        end
    end

    // transmitter with optional guard bit for the line driver
    uaxr_tx_t tx_state_q;
    logic [4:0] tcnt_q;
    logic [2:0] tbit_q;
    logic [7:0] tsh_q;
    logic [7:0] irc_q;
    logic bit_end;
    assign bit_end = tick && tcnt_q == s_max - 5'h01;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_state_q <= TX_IDLE;
            tx_ready_o <= 1'b1;
            tcnt_q <= '0;
            tbit_q <= '0;
            tsh_q <= '0;
            irc_q <= '0;
        end else begin
            irc_q <= (irc_q == 8'hff) ? irc_q : irc_q + 8'h01;
            if (tick && tx_state_q != TX_IDLE) begin
                tcnt_q <= tcnt_q + 5'h01;
            end
            if (bit_end && tx_state_q != TX_IDLE) begin
                tcnt_q <= '0;
                irc_q <= '0;
            end
            unique case (tx_state_q)
                TX_IDLE: begin
                    if (tx_valid_i && tx_ready_o) begin
                        tx_ready_o <= 1'b0;
                        tsh_q <= tx_data_i;
                        tcnt_q <= '0;
                        irc_q <= '0;
                        tx_state_q <= line_driver_mode_enable_i ? TX_GUARD : TX_START;
                    end
                end
                TX_GUARD: begin
                    if (bit_end) begin
                        tx_state_q <= TX_START;
                    end
                end
                TX_START: begin
                    if (bit_end) begin
                        tx_state_q <= TX_DATA;
                        tbit_q <= '0;
                    end
                end
                TX_DATA: begin
                    if (bit_end) begin
                        tsh_q <= {1'b0, tsh_q[7:1]};
                        tbit_q <= tbit_q + 3'h1;
                        if (tbit_q == uaxr_pkg::LAST_DATA_BIT) begin
                            tx_state_q <= TX_STOP;
                        end
                    end
                end
                TX_STOP: begin
                    if (bit_end) begin
                        tx_state_q <= TX_IDLE;
                        tx_ready_o <= 1'b1;
                    end
                end
                default: begin
                    tx_state_q <= TX_IDLE;
                end
            endcase
        end
    end

    // pin drive: infrared pulse shaping, open drain, direction
    logic tx_bit;
    logic tx_pulse;
    logic tx_level;
    assign tx_bit = (tx_state_q == TX_START) ? 1'b0 : (tx_state_q == TX_DATA) ? tsh_q[0] : 1'b1;
    always_comb begin
        unique case (ir_pulse_scheme_i)
            uaxr_pkg::IR_PULSE_316: tx_pulse = !tx_bit && tcnt_q < uaxr_pkg::IR_PULSE_TICKS;
            uaxr_pkg::IR_PULSE_FIXED: tx_pulse = !tx_bit && irc_q < ir_pulse_cycles_i;
            default: tx_pulse = !tx_bit;
        endcase
    end
    assign tx_level = infrared_mode ? !tx_pulse : tx_bit;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            txd_o <= 1'b1;
            txd_oe_o <= 1'b1;
            driver_direction_out_o <= 1'b0;
        end else begin
            txd_o <= open_drain_enable_i ? 1'b0 : tx_level;
            txd_oe_o <= open_drain_enable_i ? !tx_level : 1'b1;
            driver_direction_out_o <= line_driver_mode_enable_i && tx_state_q != TX_IDLE;
        end
    end
endmodule // uaxr_top
`default_nettype wire

// file: uaxr_pkg.sv
// constants shared by the asynchronous receive extension block
package uaxr_pkg;
    localparam logic [1:0]  RX_NORMAL_MODE      = 2'h0;
    localparam logic [1:0]  RX_DOUBLE_MODE      = 2'h1;
    localparam logic [1:0]  GENERIC_AUTOBAUD    = 2'h2;
    localparam logic [1:0]  CONSTRAINED_AUTOBD  = 2'h3;
    localparam logic [1:0]  COMM_INFRARED_MODE  = 2'h2;
    localparam logic [1:0]  IR_PULSE_316        = 2'h0;
    localparam logic [1:0]  IR_PULSE_FIXED      = 2'h1;
    localparam logic [4:0]  SAMPLES_NORMAL      = 5'h10;
    localparam logic [4:0]  SAMPLES_DOUBLE      = 5'h08;
    localparam logic [4:0]  VOTE_FIRST_NORMAL   = 5'h08;
    localparam logic [4:0]  VOTE_MID_NORMAL     = 5'h09;
    localparam logic [4:0]  VOTE_FIRST_DOUBLE   = 5'h04;
    localparam logic [4:0]  VOTE_MID_DOUBLE     = 5'h05;
    localparam logic [4:0]  IR_PULSE_TICKS      = 5'h03;
    localparam logic [3:0]  BREAK_MIN_CYCLES    = 4'hc;
    localparam logic [2:0]  SYNC_FALL_EDGES     = 3'h4;
    localparam logic [16:0] TICK_STEP           = 17'h00080;
    localparam logic [16:0] BAUD_VALID_MIN      = 17'h00064;
    localparam logic [16:0] BAUD_VALID_MAX      = 17'h0ffff;
    localparam logic [15:0] BAUD_RESET          = 16'h0400;
    localparam logic [2:0]  LAST_DATA_BIT       = 3'h7;
endpackage

// file: uaxr_assertions.sv
// port-level checks for the receive extension block
`timescale 1ns/1ps
`default_nettype none
module uaxr_assertions (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic [1:0]  receive_mode_select_i,
    input wire logic        open_drain_enable_i,
    input wire logic        line_driver_mode_enable_i,
    input wire logic        tx_valid_i,
    input wire logic        baud_load_i,
    input wire logic        sync_mismatch_clear_i,
    input wire logic        rx_ready_i,
    input wire logic        txd_o,
    input wire logic        txd_oe_o,
    input wire logic        driver_direction_out_o,
    input wire logic        tx_ready_o,
    input wire logic        rx_valid_o,
    input wire logic [7:0]  rx_data_o,
    input wire logic [15:0] baud_o,
    input wire logic        sync_field_mismatch_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // transmit wire released or driven high
    wire line_high = !txd_oe_o || txd_o;
    // transmit pin and line driver direction
    property p_open_drain; open_drain_enable_i && $past(open_drain_enable_i) && !$past(reset_i) |-> !(txd_oe_o && txd_o); endproperty
    a_open_drain: assert property (p_open_drain) else $error("transmit pin driven high in open drain");
    property p_dir_guard; tx_valid_i && tx_ready_o && line_driver_mode_enable_i |-> ##3 (driver_direction_out_o && line_high) [*8]; endproperty
    a_dir_guard: assert property (p_dir_guard) else $error("direction not raised ahead of start bit");
    property p_dir_fall; $fell(driver_direction_out_o) && line_driver_mode_enable_i |-> $past(tx_ready_o); endproperty
    a_dir_fall: assert property (p_dir_fall) else $error("direction fell before frame end");
    property p_idle_high; tx_ready_o && $past(tx_ready_o) |-> line_high; endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle transmit line not high");
    // auto-baud flag and setting
    property p_flag_sticky; sync_field_mismatch_flag_o && !sync_mismatch_clear_i |=> sync_field_mismatch_flag_o; endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("mismatch flag lost");
    property p_flag_baud; $rose(sync_field_mismatch_flag_o) && !$past(baud_load_i) |-> $stable(baud_o); endproperty
    a_flag_baud: assert property (p_flag_baud) else $error("baud changed on sync mismatch");
    property p_baud_hold;
        !receive_mode_select_i[1] && !$past(receive_mode_select_i[1]) && !baud_load_i |=> $stable(baud_o);
    endproperty
    a_baud_hold: assert property (p_baud_hold) else $error("baud changed outside auto-baud");
    // receive word stands until taken
    property p_rx_hold; rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o); endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receive word dropped while stalled");
endmodule // uaxr_assertions
bind uaxr_top uaxr_assertions u_chk (.clk_i(clk_i), .reset_i(reset_i), .receive_mode_select_i(receive_mode_select_i),
    .open_drain_enable_i(open_drain_enable_i), .line_driver_mode_enable_i(line_driver_mode_enable_i),
    .tx_valid_i(tx_valid_i), .baud_load_i(baud_load_i), .sync_mismatch_clear_i(sync_mismatch_clear_i),
    .rx_ready_i(rx_ready_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .driver_direction_out_o(driver_direction_out_o),
    .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .baud_o(baud_o),
    .sync_field_mismatch_flag_o(sync_field_mismatch_flag_o));
`default_nettype wire

// file: uaxr_line_model.sv
// remote serial node: drives the receive line or the infrared event line
`timescale 1ns/1ps
`default_nettype none
module uaxr_line_model (
    input  wire logic clk_i,
    output var logic  line_o,
    output var logic  ev_o
);
    // idle: pulled-up line high, event low
    initial begin
        line_o = 1'h1;
        ev_o = 1'h0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // break: low for n clocks, then high for gap clocks
    task automatic brk(input int n, input int gap);
        line_o = 1'h0;
        wait_clk(n);
        line_o = 1'h1;
        wait_clk(gap);
    endtask
    // start, 8 data lsb first, stop; bits from slow on twice as long; irw>0 pulses zero bits
    task automatic send(input logic [7:0] d, input int per, input int slow, input int irw, input bit to_ev);
        logic [9:0] f;
        int len;
        f = {1'h1, d, 1'h0};
        for (int i = 0; i < 10; i++) begin
            len = (i >= slow) ? 2 * per : per;
            if (irw > 0 && !f[i]) begin
                ev_o = to_ev;
                line_o = to_ev;
                wait_clk(irw);
                ev_o = 1'h0;
                line_o = 1'h1;
                wait_clk(len - irw);
            end else begin
                line_o = (irw > 0) ? 1'h1 : f[i];
                wait_clk(len);
            end
        end
    endtask
endmodule // uaxr_line_model
`default_nettype wire

// file: tb.sv
// self-checking bench for the receive extension block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_i = 1'h0;
    logic        reset_i = 1'h1;
    logic [1:0]  rm = 2'h0, cm = 2'h0, sch = 2'h0;
    logic        wb = 1'h0, lb = 1'h0, od = 1'h0, ld = 1'h0, es = 1'h0, ldb = 1'h0, clr = 1'h0;
    logic        txv = 1'h0, rdy = 1'h0, rlow = 1'h0;
    logic [7:0]  tdat = 8'h00;
    wire logic   line, ev, txd, oe, dir, txr, rxv, ferr, ovr, flag, twire;
    wire logic [7:0]  rdat;
    wire logic [15:0] baud;
    int          n_mismatch = 0, checks = 0, ovrs = 0, dirs = 0;
    assign twire = oe ? txd : 1'h1;
    always #5 clk_i = ~clk_i;
    uaxr_line_model model (.clk_i(clk_i), .line_o(line), .ev_o(ev));
    uaxr_top dut (.clk_i(clk_i), .reset_i(reset_i), .receive_mode_select_i(rm), .communication_mode_select_i(cm),
        .wait_break_any_length_i(wb), .loopback_enable_i(lb), .open_drain_enable_i(od),
        .line_driver_mode_enable_i(ld), .ir_event_select_i(es), .ir_event_i(ev), .ir_pulse_scheme_i(sch),
        .ir_pulse_cycles_i(8'h08), .ir_min_width_i(8'h04), .baud_load_i(ldb), .baud_i(16'h0100),
        .sync_mismatch_clear_i(clr), .rxd_i(rlow ? 1'h0 : line), .txd_i(twire), .tx_valid_i(txv),
        .tx_data_i(tdat), .rx_ready_i(rdy), .txd_o(txd), .txd_oe_o(oe), .driver_direction_out_o(dir),
        .tx_ready_o(txr), .rx_valid_o(rxv), .rx_data_o(rdat), .rx_frame_error_o(ferr), .rx_overrun_o(ovr),
        .baud_o(baud), .sync_field_mismatch_flag_o(flag));
    // count overrun pulses and direction-high cycles
    always @(posedge clk_i) begin
        if (ovr === 1'h1) ovrs++;
        if (dir === 1'h1) dirs++;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got, input int tol = 0);
        checks++;
        if (((got - exp + tol) <= 2 * tol) !== 1'h1) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // wait for a word, compare, accept it
    task automatic rx(input logic [7:0] d);
        for (int i = 0; i < 4000 && rxv !== 1'h1; i++) step(1);
        chk("rx_valid", 16'h0001, {15'h0000, rxv});
        chk("rx_data", {8'h00, d}, {8'h00, rdat});
        chk("frame_error", 16'h0000, {15'h0000, ferr});
        rdy = 1'h1;
        step(1);
        rdy = 1'h0;
        step(1);
    endtask
    task automatic rxs(input logic [7:0] d, input int per, input int irw, input bit to_ev);
        fork
            model.send(d, per, 10, irw, to_ev);
            rx(d);
        join
    endtask
    task automatic txs(input logic [7:0] d);
        for (int i = 0; i < 4000 && txr !== 1'h1; i++) step(1);
        chk("tx_ready", 16'h0001, {15'h0000, txr});
        tdat = d;
        txv = 1'h1;
        step(1);
        txv = 1'h0;
        rx(d);
    endtask
    // restart the detector, send break and sync, compare the baud setting
    task automatic autob(input logic [1:0] m, input logic w, input int bn, input int per, input int slow,
                         input logic [15:0] exp);
        rm = 2'h0;
        step(1);
        rm = m;
        wb = w;
        step(1);
        model.brk(bn, per);
        model.send(8'h55, per, slow, 0, 0);
        step(40);
        chk("baud", exp, baud, 1);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        end_sim;
    end
    initial begin
        step(3);
        reset_i = 1'h0;
        ldb = 1'h1;
        step(1);
        ldb = 1'h0;
        rxs(8'ha5, 32, 0, 0);
        rm = 2'h1;
        rxs(8'h3c, 16, 0, 0);
        $display("test speeds done");
        cm = 2'h2;
        rxs(8'h5a, 32, 6, 0);
        model.send(8'h5a, 32, 10, 2, 0);
        chk("short_pulse_valid", 16'h0000, {15'h0000, rxv});
        es = 1'h1;
        rlow = 1'h1;
        rxs(8'hc3, 32, 6, 1);
        es = 1'h0;
        lb = 1'h1;
        rm = 2'h0;
        for (int s = 0; s < 3; s++) begin
            sch = s[1:0];
            txs(8'hd5);
        end
        $display("test infrared done");
        cm = 2'h0;
        od = 1'h1;
        ld = 1'h1;
        txs(8'h69);
        step(40);
        chk("dir_high_seen", 16'h0001, {15'h0000, dirs > 0});
        chk("dir_after_frame", 16'h0000, {15'h0000, dir});
        $display("test one-wire done");
        {lb, od, ld, rlow} = 4'h0;
        for (int k = 1; k < 5; k++) model.send(k[7:0], 32, 10, 0, 0);
        chk("overruns", 16'h0001, ovrs[15:0]);
        for (int k = 1; k < 4; k++) rx(k[7:0]);
        chk("rx_empty", 16'h0000, {15'h0000, rxv});
        $display("test buffer done");
        autob(2'h2, 1'h0, 200, 40, 10, 16'h0140);
        autob(2'h2, 1'h0, 200, 8, 10, 16'h0140);
        autob(2'h2, 1'h1, 4, 20, 10, 16'h00a0);
        autob(2'h3, 1'h1, 4, 24, 10, 16'h00a0);
        autob(2'h3, 1'h0, 200, 24, 10, 16'h00c0);
        autob(2'h3, 1'h0, 200, 24, 3, 16'h00c0);
        chk("mismatch_flag", 16'h0001, {15'h0000, flag});
        clr = 1'h1;
        step(1);
        clr = 1'h0;
        step(1);
        chk("flag_cleared", 16'h0000, {15'h0000, flag});
        $display("test auto-baud done");
        end_sim;
    end
endmodule // tb
`default_nettype wire
